// ===== logic/aem_pkg.sv
`default_nettype none
package aem_pkg;
	// field sizes
	localparam int DATA_BYTES = 128;
	localparam int PAGE_BYTES = 32;
	localparam int PAGE_COUNT = 4;
	localparam int STATUS_BYTES = 8;
	localparam logic [15:0] DATA_ADDR_MASK = 16'h007F;
	localparam logic [15:0] STAT_ADDR_MASK = 16'h0007;
	localparam logic [15:0] DATA_LAST = 16'h007F;
	localparam logic [15:0] STAT_LAST = 16'h0007;
	localparam int LOCK_BYTE_IDX = 0;
	// command codes
	localparam logic [7:0] CMD_READ_MEM = 8'hF0;
	localparam logic [7:0] CMD_READ_STAT = 8'hAA;
	localparam logic [7:0] CMD_WRITE_MEM = 8'h0F;
	localparam logic [7:0] CMD_WRITE_STAT = 8'h55;
	// stored values
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam logic [7:0] FACTORY_ZERO = 8'h00;
	localparam logic [7:0] CRC_INIT = 8'h00;
	localparam logic [7:0] CRC_POLY_REFL = 8'h8C;
	// timing at a 40 MHz clock
	localparam int CLOCK_MHZ = 40;
	localparam int SLOT_TIME_US = 60;
	localparam int SLOT_CYCLES = SLOT_TIME_US * CLOCK_MHZ;
	localparam int PROG_TIME_US = 480;
	localparam int PROG_CYCLES = PROG_TIME_US * CLOCK_MHZ;

	typedef enum logic [3:0] {D_WAIT_ROM, D_CMD, D_ADDR_LO, D_ADDR_HI, D_HDR_CRC, D_RD_DATA, D_END_CRC,
		D_ONES, D_WR_DATA, D_WR_CRC, D_WR_PROG, D_WR_VERIFY} aem_dev_state_t;
	typedef enum logic [3:0] {M_IDLE, M_RESET, M_ROM, M_SEND, M_GET_CRC, M_READ, M_PROG, M_VERIFY,
		M_FINISH} aem_mst_state_t;

	// one bit of x^8+x^5+x^4+1, lsb first
	function automatic logic [7:0] aem_crc_bit(input logic [7:0] crc, input logic inBit);
		logic fb;
		fb = crc[0] ^ inBit;
		aem_crc_bit = fb ? ((crc >> 1) ^ CRC_POLY_REFL) : (crc >> 1);
	endfunction : aem_crc_bit
endpackage : aem_pkg
`default_nettype wire

// ===== logic/aem_link_if.sv
`timescale 1ns/10ps
`default_nettype none
// logic-level view of the single-wire line: slots, reset, programming level
interface aem_link_if;
	logic slot;
	logic slotWrite;
	logic slotBit;
	logic busReset;
	logic romDone;
	logic progLevel;
	logic replyBit;
	modport dev(input slot, input slotWrite, input slotBit, input busReset, input romDone, input progLevel,
		output replyBit);
	modport mst(output slot, output slotWrite, output slotBit, output busReset, output romDone,
		output progLevel, input replyBit);
endinterface : aem_link_if
`default_nettype wire

// ===== logic/aem_device.sv
// Overview of operation
// - data field: four pages of 32 bytes
// - byte goes scratchpad, crc check, then programming
// - separate 64-bit status field, own commands
// - lock bit stops programming its page
// - redirection bytes steer no hardware
// - programming only clears bits
// - software reads redirection byte, ff valid
// - master sends command and two address bytes
// - writes one byte at a time, programming level
// - read runs to field end or reset
// - every bit travels lsb first
// - data read is f0, low address first
// - header crc sent before read data
// - master resets on header crc mismatch
// - crc of read bytes after memory end
// - ones after closing crc until reset
// - no closing crc when read aborted
// - status read is aa, streams to end
// - status crc includes final zero byte
// - ones after status crc, reset aborts
// - master may reset at memory end
// - crc x8+x5+x4+1, zero start, lsb first
// - memory commands only after rom sequence
`timescale 1ns/10ps
`default_nettype none
module aem_device import aem_pkg::*; (
	input wire logic clock,
	input wire logic rst_n,
	aem_link_if.dev link,
	output logic [PAGE_COUNT-1:0] pageLocked,
	output logic memActive
);
	aem_dev_state_t state;
	logic [7:0] cmd;
	logic [15:0] addr;
	logic [7:0] rxShift;
	logic [7:0] txShift;
	logic [2:0] bitCnt;
	logic [7:0] crc;
	logic [7:0] scratch;
	logic progSeen;
	logic [7:0] dataMem [0:DATA_BYTES-1];
	logic [7:0] statMem [0:STATUS_BYTES-1];

	logic readSlot;
	logic writeSlot;
	logic byteDone;
	logic [7:0] rxByte;
	logic [7:0] crcNext;
	logic isStatus;
	logic [15:0] addrMask;
	logic [15:0] fieldLast;
	logic [15:0] addrInc;
	logic progRise;
	logic pageLock;
	logic [7:0] progValue;

	// byte of the selected field; out-of-field bits are masked off by the caller
	function automatic logic [7:0] readField(input logic stat, input logic [15:0] a);
		readField = stat ? statMem[a[2:0]] : dataMem[a[6:0]];
	endfunction : readField

	// slot decode and shared datapath terms
	assign readSlot = link.slot && !link.slotWrite;
	assign writeSlot = link.slot && link.slotWrite;
	assign byteDone = (bitCnt == 3'h7);
	assign rxByte = {link.slotBit, rxShift[7:1]};
	assign crcNext = aem_crc_bit(crc, writeSlot ? link.slotBit : txShift[0]);
	assign isStatus = (cmd == CMD_READ_STAT) || (cmd == CMD_WRITE_STAT);
	assign addrMask = isStatus ? STAT_ADDR_MASK : DATA_ADDR_MASK;
	assign fieldLast = isStatus ? STAT_LAST : DATA_LAST;
	assign addrInc = (addr + 16'h0001) & addrMask;
	// the programming level comes from logic on this clock, so no synchroniser
	assign progRise = link.progLevel && !progSeen;
	assign pageLock = !statMem[LOCK_BYTE_IDX][addr[6:5]];
	assign progValue = (!isStatus && pageLock) ? readField(isStatus, addr) : (readField(isStatus, addr) & scratch);
	// idle reply is a one, so a stray read slot always sees ones
	assign link.replyBit = txShift[0];

	// programming level edge tracker
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			progSeen <= 1'b0;
		end else begin
			progSeen <= link.progLevel;
		end
	end

	// user-side flags; a cleared lock bit means the page is write protected
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			memActive <= 1'b0;
			pageLocked <= {PAGE_COUNT{1'b0}};
		end else begin
			memActive <= (state != D_WAIT_ROM);
			pageLocked <= ~statMem[LOCK_BYTE_IDX][PAGE_COUNT-1:0];
		end
	end

	// eprom cells: erased to ones at reset, last status byte factory zero
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < DATA_BYTES; i++) begin
				dataMem[i] <= ERASED_BYTE;
			end
			for (int j = 0; j < STATUS_BYTES - 1; j++) begin
				statMem[j] <= ERASED_BYTE;
			end
			statMem[STATUS_BYTES-1] <= FACTORY_ZERO;
		end else if (state == D_WR_PROG && progRise && !link.busReset) begin
			// and-in only: a zero can never return to one
			if (isStatus) begin
				statMem[addr[2:0]] <= statMem[addr[2:0]] & scratch;
			end else if (!pageLock) begin
				dataMem[addr[6:0]] <= dataMem[addr[6:0]] & scratch;
			end
		end
	end

	// command sequencer
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= D_WAIT_ROM;
			cmd <= 8'h00;
			addr <= 16'h0000;
			rxShift <= 8'h00;
			txShift <= ERASED_BYTE;
			bitCnt <= 3'h0;
			crc <= CRC_INIT;
			scratch <= ERASED_BYTE;
		end else if (link.busReset) begin
			// partial bytes and crc are dropped; address and command are kept
			state <= D_WAIT_ROM;
			bitCnt <= 3'h0;
			txShift <= ERASED_BYTE;
			crc <= CRC_INIT;
		end else begin
			case (state)
				D_WAIT_ROM: begin
					if (link.romDone) begin
						state <= D_CMD;
						bitCnt <= 3'h0;
						crc <= CRC_INIT;
					end
				end
				D_CMD, D_ADDR_LO, D_ADDR_HI, D_WR_DATA: begin
					if (writeSlot) begin
						rxShift <= rxByte;
						crc <= crcNext;
						bitCnt <= bitCnt + 3'h1;
						if (byteDone) begin
							case (state)
								D_CMD: begin
									cmd <= rxByte;
									if (rxByte == CMD_READ_MEM || rxByte == CMD_READ_STAT ||
										rxByte == CMD_WRITE_MEM || rxByte == CMD_WRITE_STAT) begin
										state <= D_ADDR_LO;
									end else begin
										state <= D_ONES;
									end
								end
								D_ADDR_LO: begin
									addr[7:0] <= rxByte;
									state <= D_ADDR_HI;
								end
								D_ADDR_HI: begin
									// out-of-field high bits are forced to zero
									addr <= {rxByte, addr[7:0]} & addrMask;
									if (cmd == CMD_READ_MEM || cmd == CMD_READ_STAT) begin
										txShift <= crcNext;
										state <= D_HDR_CRC;
									end else begin
										state <= D_WR_DATA;
									end
								end
								default: begin
									scratch <= rxByte;
									txShift <= crcNext;
									state <= D_WR_CRC;
								end
							endcase
						end
					end
				end
				D_HDR_CRC, D_RD_DATA, D_END_CRC, D_WR_CRC, D_WR_VERIFY: begin
					if (readSlot) begin
						txShift <= {1'b1, txShift[7:1]};
						bitCnt <= bitCnt + 3'h1;
						if (state == D_RD_DATA) begin
							crc <= crcNext;
						end
						if (byteDone) begin
							case (state)
								D_HDR_CRC: begin
									crc <= CRC_INIT;
									txShift <= readField(isStatus, addr);
									state <= D_RD_DATA;
								end
								D_RD_DATA: begin
									if (addr == fieldLast) begin
										txShift <= crcNext;
										state <= D_END_CRC;
									end else begin
										addr <= addrInc;
										txShift <= readField(isStatus, addrInc);
									end
								end
								D_END_CRC: begin
									txShift <= ERASED_BYTE;
									state <= D_ONES;
								end
								D_WR_CRC: begin
									txShift <= ERASED_BYTE;
									state <= D_WR_PROG;
								end
								default: begin
									// next byte: crc preloaded with new low address
									addr <= addrInc;
									crc <= addrInc[7:0];
									state <= D_WR_DATA;
								end
							endcase
						end
					end
				end
				D_WR_PROG: begin
					if (progRise) begin
						txShift <= progValue;
						bitCnt <= 3'h0;
						state <= D_WR_VERIFY;
					end
				end
				D_ONES: begin
					txShift <= ERASED_BYTE;
				end
				default: begin
					state <= D_WAIT_ROM;
				end
			endcase
		end
	end
endmodule : aem_device
`default_nettype wire

// ===== logic/aem_master.sv
`timescale 1ns/10ps
`default_nettype none
module aem_master import aem_pkg::*; #(
	parameter int SLOT_CYC = SLOT_CYCLES,
	parameter int PROG_CYC = PROG_CYCLES
) (
	input wire logic clock,
	input wire logic rst_n,
	aem_link_if.mst link,
	input wire logic opStart,
	input wire logic [7:0] opCmd,
	input wire logic [15:0] opAddr,
	input wire logic [7:0] opData,
	input wire logic [7:0] opCount,
	output logic busy,
	output logic [7:0] rdByte,
	output logic rdValid,
	output logic opDone,
	output logic opError
);
	aem_mst_state_t state;
	logic [23:0] divCnt;
	logic tick;
	logic [23:0] progCnt;
	logic [2:0] bitCnt;
	logic [1:0] byteIdx;
	logic [7:0] shift;
	logic [7:0] crc;
	logic [7:0] cmd;
	logic [15:0] addr;
	logic [7:0] data;
	logic [7:0] count;
	logic isWrite;
	logic [7:0] gotByte;

	function automatic logic [7:0] sendByte(input logic [1:0] idx, input logic [7:0] c, input logic [15:0] a,
		input logic [7:0] d);
		case (idx)
			2'h0: sendByte = c;
			2'h1: sendByte = a[7:0];
			2'h2: sendByte = a[15:8];
			default: sendByte = d;
		endcase
	endfunction : sendByte

	assign isWrite = (cmd == CMD_WRITE_MEM) || (cmd == CMD_WRITE_STAT);
	assign gotByte = {link.replyBit, shift[7:1]};

	// slot pacing divider; a slot is one cycle wide, spacing SLOT_CYC
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			divCnt <= 24'h00_0000;
			tick <= 1'b0;
		end else if (divCnt == 24'(SLOT_CYC - 1)) begin
			divCnt <= 24'h00_0000;
			tick <= 1'b1;
		end else begin
			divCnt <= divCnt + 24'h00_0001;
			tick <= 1'b0;
		end
	end

	// transaction sequencer
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= M_IDLE;
			link.slot <= 1'b0;
			link.slotWrite <= 1'b0;
			link.slotBit <= 1'b1;
			link.busReset <= 1'b0;
			link.romDone <= 1'b0;
			link.progLevel <= 1'b0;
			progCnt <= 24'h00_0000;
			bitCnt <= 3'h0;
			byteIdx <= 2'h0;
			shift <= 8'h00;
			crc <= CRC_INIT;
			cmd <= 8'h00;
			addr <= 16'h0000;
			data <= 8'h00;
			count <= 8'h00;
			busy <= 1'b0;
			rdByte <= 8'h00;
			rdValid <= 1'b0;
			opDone <= 1'b0;
			opError <= 1'b0;
		end else begin
			// strobes last one cycle
			link.slot <= 1'b0;
			link.busReset <= 1'b0;
			link.romDone <= 1'b0;
			rdValid <= 1'b0;
			opDone <= 1'b0;
			case (state)
				M_IDLE: begin
					if (opStart) begin
						cmd <= opCmd;
						addr <= opAddr;
						data <= opData;
						count <= opCount;
						busy <= 1'b1;
						opError <= 1'b0;
						state <= M_RESET;
					end
				end
				M_RESET: begin
					if (tick) begin
						link.busReset <= 1'b1;
						state <= M_ROM;
					end
				end
				M_ROM: begin
					if (tick) begin
						link.romDone <= 1'b1;
						crc <= CRC_INIT;
						bitCnt <= 3'h0;
						byteIdx <= 2'h0;
						shift <= cmd;
						state <= M_SEND;
					end
				end
				M_SEND: begin
					if (tick) begin
						link.slot <= 1'b1;
						link.slotWrite <= 1'b1;
						link.slotBit <= shift[0];
						crc <= aem_crc_bit(crc, shift[0]);
						shift <= shift >> 1;
						bitCnt <= bitCnt + 3'h1;
						if (bitCnt == 3'h7) begin
							byteIdx <= byteIdx + 2'h1;
							shift <= sendByte(byteIdx + 2'h1, cmd, addr, data);
							if (byteIdx == (isWrite ? 2'h3 : 2'h2)) begin
								state <= M_GET_CRC;
							end
						end
					end
				end
				M_GET_CRC, M_READ, M_VERIFY: begin
					if (tick) begin
						link.slot <= 1'b1;
						link.slotWrite <= 1'b0;
						shift <= gotByte;
						bitCnt <= bitCnt + 3'h1;
						if (bitCnt == 3'h7) begin
							case (state)
								M_GET_CRC: begin
									if (gotByte != crc) begin
										opError <= 1'b1;
										state <= M_FINISH;
									end else if (isWrite) begin
										// level waits a cycle so the last crc slot is not overlapped
										progCnt <= 24'h00_0000;
										state <= M_PROG;
									end else if (count == 8'h00) begin
										state <= M_FINISH;
									end else begin
										state <= M_READ;
									end
								end
								M_READ: begin
									rdByte <= gotByte;
									rdValid <= 1'b1;
									count <= count - 8'h01;
									if (count == 8'h01) begin
										state <= M_FINISH;
									end
								end
								default: begin
									rdByte <= gotByte;
									rdValid <= 1'b1;
									// a one left where a zero was asked for is a failure
									opError <= |(gotByte & ~data);
									state <= M_FINISH;
								end
							endcase
						end
					end
				end
				M_PROG: begin
					// high for PROG_CYC cycles, starting on the same edge that the slot strobe drops
					progCnt <= progCnt + 24'h00_0001;
					if (progCnt == 24'(PROG_CYC)) begin
						link.progLevel <= 1'b0;
						bitCnt <= 3'h0;
						state <= M_VERIFY;
					end else begin
						link.progLevel <= 1'b1;
					end
				end
				M_FINISH: begin
					if (tick) begin
						link.busReset <= 1'b1;
						opDone <= 1'b1;
						busy <= 1'b0;
						state <= M_IDLE;
					end
				end
				default: begin
					state <= M_IDLE;
				end
			endcase
		end
	end
endmodule : aem_master
`default_nettype wire

// ===== test/aem_link_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module aem_link_asserts #(
	parameter int PROG_CYC = 8
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic slot,
	input wire logic slotWrite,
	input wire logic slotBit,
	input wire logic busReset,
	input wire logic romDone,
	input wire logic progLevel,
	input wire logic replyBit
);
	logic armed;
	int highCnt;
	// memory layer open from romDone until a line reset
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			armed <= 1'b0;
		end else if (busReset) begin
			armed <= 1'b0;
		end else if (romDone) begin
			armed <= 1'b1;
		end
	end
	// run length of the programming level, to bound the pulse
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			highCnt <= 0;
		end else begin
			highCnt <= progLevel ? highCnt + 1 : 0;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_slot_spacing: assert property (slot |=> !slot [*3])
		else $error("slots closer than one slot period");
	a_slot_after_rom: assert property (slot |-> armed)
		else $error("slot before rom sequence");
	a_rom_once: assert property (romDone |-> !armed && !slot && !busReset)
		else $error("rom done while memory layer open");
	a_reset_alone: assert property (busReset |-> !slot && !romDone && !progLevel)
		else $error("reset pulse mixed with other strobes");
	a_idle_ones: assert property (!armed |-> replyBit)
		else $error("reply not one while closed");
	a_reply_stands: assert property ($changed(replyBit) |->
		$past(slot) || $past(busReset) || ($past(progLevel) != $past(progLevel, 2)))
		else $error("reply changed without a slot");
	a_prog_quiet: assert property (progLevel |-> !slot && !busReset)
		else $error("slot during programming level");
	a_prog_length: assert property ($fell(progLevel) |-> highCnt >= PROG_CYC)
		else $error("programming pulse too short");
endmodule : aem_link_asserts
`default_nettype wire

// ===== test/addonly_eprom_memory_functions_test.sv
`timescale 1ns/10ps
`default_nettype none
module addonly_eprom_memory_functions_test import aem_pkg::*; ;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic opStart = 1'b0;
	logic [7:0] opCmd = 8'h00;
	logic [15:0] opAddr = 16'h0000;
	logic [7:0] opData = 8'h00;
	logic [7:0] opCount = 8'h00;
	logic busy, rdValid, opDone, opError, memActive, sawActive;
	logic [7:0] rdByte;
	logic [3:0] pageLocked;
	logic [7:0] got[$];
	logic [7:0] exp[$];
	int fails = 0;
	int compares = 0;
	aem_link_if link();
	aem_device aem_device_i(.clock(clock), .rst_n(rst_n), .link(link.dev), .pageLocked(pageLocked),
		.memActive(memActive));
	// short slot and pulse so a full sequence stays a few hundred cycles
	aem_master #(.SLOT_CYC(4), .PROG_CYC(8)) aem_master_i(.clock(clock), .rst_n(rst_n), .link(link.mst),
		.opStart(opStart), .opCmd(opCmd), .opAddr(opAddr), .opData(opData), .opCount(opCount), .busy(busy),
		.rdByte(rdByte), .rdValid(rdValid), .opDone(opDone), .opError(opError));
	aem_link_asserts #(.PROG_CYC(8)) aem_link_asserts_i(.clock(clock), .rst_n(rst_n), .slot(link.slot),
		.slotWrite(link.slotWrite), .slotBit(link.slotBit), .busReset(link.busReset), .romDone(link.romDone),
		.progLevel(link.progLevel), .replyBit(link.replyBit));
	// 40 MHz
	always #12.5 clock = ~clock;
	task automatic complete_run;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : complete_run
	task automatic check_byte(input logic [7:0] act, input logic [7:0] want, input string what);
		compares++;
		if (act !== want) begin
			fails++;
			$display("ERROR %0t: %s is %h, expected %h", $time, what, act, want);
		end
	endtask : check_byte
	task automatic check_bit(input logic act, input logic want, input string what);
		check_byte({7'h00, act}, {7'h00, want}, what);
	endtask : check_bit
	// reference crc kept apart from the design's own helper
	function automatic logic [7:0] crc_of(input logic [7:0] b[$]);
		logic [7:0] c;
		c = 8'h00;
		foreach (b[i]) begin
			for (int k = 0; k < 8; k++) begin
				c = (c[0] ^ b[i][k]) ? ((c >> 1) ^ 8'h8C) : (c >> 1);
			end
		end
		return c;
	endfunction : crc_of
	// one whole transaction, bytes gathered as they appear
	task automatic run_op(input logic [7:0] cmd, input logic [15:0] addr, input logic [7:0] data,
		input logic [7:0] cnt);
		int n;
		got.delete();
		sawActive = 1'b0;
		n = 0;
		@(posedge clock);
		opStart <= 1'b1;
		opCmd <= cmd;
		opAddr <= addr;
		opData <= data;
		opCount <= cnt;
		@(posedge clock);
		opStart <= 1'b0;
		while (opDone !== 1'b1) begin
			@(posedge clock);
			if (rdValid === 1'b1) got.push_back(rdByte);
			if (memActive === 1'b1) sawActive = 1'b1;
			n++;
			if (n > 20000) begin
				fails++;
				$display("ERROR %0t: operation hung", $time);
				complete_run();
			end
		end
	endtask : run_op
	task automatic check_got(input string what);
		check_byte(8'(got.size()), 8'(exp.size()), {what, " count"});
		if (got.size() == exp.size()) foreach (exp[i]) check_byte(got[i], exp[i], what);
		$display("test %s done", what);
	endtask : check_got
	// reset, then the sequences
	initial begin
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		check_bit(memActive, 1'b0, "closed layer");
		run_op(CMD_READ_MEM, 16'h007E, 8'h00, 8'h04);
		exp = {8'hFF, 8'hFF, crc_of({8'hFF, 8'hFF}), 8'hFF};
		check_bit(opError, 1'b0, "header crc");
		check_bit(sawActive, 1'b1, "layer opened");
		check_got("tail read");
		check_bit(busy, 1'b0, "idle after op");
		run_op(CMD_WRITE_MEM, 16'h0005, 8'hA5, 8'h00);
		exp = {8'hA5};
		check_bit(opError, 1'b0, "write error");
		check_got("first write");
		run_op(CMD_WRITE_MEM, 16'h0005, 8'h0F, 8'h00);
		exp = {8'h05};
		check_got("second write");
		run_op(CMD_READ_MEM, 16'h0004, 8'h00, 8'h03);
		exp = {8'hFF, 8'h05, 8'hFF};
		check_got("mid read");
		run_op(CMD_WRITE_STAT, 16'h0000, 8'hFE, 8'h00);
		exp = {8'hFE};
		check_byte({4'h0, pageLocked}, 8'h01, "lock flags");
		check_got("lock write");
		run_op(CMD_WRITE_MEM, 16'h0001, 8'h00, 8'h00);
		exp = {8'hFF};
		check_bit(opError, 1'b1, "locked error");
		check_got("locked write");
		run_op(CMD_WRITE_STAT, 16'h0001, 8'hFD, 8'h00);
		exp = {8'hFD};
		check_got("redirect byte");
		run_op(CMD_WRITE_MEM, 16'h0020, 8'h3C, 8'h00);
		exp = {8'h3C};
		check_bit(opError, 1'b0, "redirected page");
		check_got("redirected write");
		run_op(CMD_READ_MEM, 16'h001F, 8'h00, 8'h02);
		exp = {8'hFF, 8'h3C};
		check_got("page cross");
		run_op(CMD_READ_STAT, 16'h0000, 8'h00, 8'h0A);
		exp = {8'hFE, 8'hFD, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00};
		exp = {exp, crc_of(exp), 8'hFF};
		check_got("status read");
		run_op(CMD_READ_STAT, 16'h0106, 8'h00, 8'h03);
		exp = {8'hFF, 8'h00, crc_of({8'hFF, 8'h00})};
		check_bit(opError, 1'b0, "high address crc");
		check_got("status tail");
		complete_run();
	end
endmodule : addonly_eprom_memory_functions_test
`default_nettype wire
